// ### hw/ufic_pkg.sv
// package of the fifo control and interrupt block of a serial element
// assumes one 100 MHz clock and a receiver clock enable at sixteen ticks per bit
package ufic_pkg;

  // ****************************************
  // register indices (byte address is four times the index)
  // ****************************************
  localparam logic [2:0] UFIC_IDX_DATA  = 3'h0;  // receive_buffer / transmit_holding
  localparam logic [2:0] UFIC_IDX_IEN   = 3'h1;  // interrupt_enable
  localparam logic [2:0] UFIC_IDX_IID   = 3'h2;  // interrupt_identification / fifo_control
  localparam logic [2:0] UFIC_IDX_LCTL  = 3'h3;  // line control
  localparam logic [2:0] UFIC_IDX_LSTAT = 3'h5;  // line_status
  localparam logic [2:0] UFIC_IDX_MSTAT = 3'h6;  // modem_status

  // ****************************************
  // field positions
  // ****************************************
  localparam int UFIC_FC_EN    = 0;  // fifo_enable_bit
  localparam int UFIC_FC_RXCLR = 1;
  localparam int UFIC_FC_TXCLR = 2;
  localparam int UFIC_FC_DMA   = 3;
  localparam int UFIC_LC_STB   = 2;  // two stop bits
  localparam int UFIC_LC_PEN   = 3;  // parity enable
  localparam int UFIC_LC_DIVISOR_ACCESS_BIT  = 7;  // divisor_access_bit

  // ****************************************
  // identification codes, trigger levels, sizes, timing
  // ****************************************
  localparam logic [3:0] UFIC_IID_NONE = 4'h1;
  localparam logic [3:0] UFIC_IID_RLS  = 4'h6;
  localparam logic [3:0] UFIC_IID_RDA  = 4'h4;
  localparam logic [3:0] UFIC_IID_CTO  = 4'hC;
  localparam logic [3:0] UFIC_IID_TRANSMIT_HOLDING_EMPTY = 4'h2;
  localparam logic [3:0] UFIC_IID_MSI  = 4'h0;
  localparam logic [4:0] UFIC_TRIG_L0  = 5'h01;
  localparam logic [4:0] UFIC_TRIG_L1  = 5'h04;
  localparam logic [4:0] UFIC_TRIG_L2  = 5'h08;
  localparam logic [4:0] UFIC_TRIG_L3  = 5'h0E;
  localparam logic [4:0] UFIC_DEPTH    = 5'h10;  // entries per fifo
  localparam logic [4:0] UFIC_CHR_CAP  = 5'h01;  // holding depth in character mode
  localparam logic [7:0] UFIC_TICKS    = 8'h10;  // receiver ticks per bit
  localparam logic [9:0] UFIC_TO_TICKS = 10'h040;  // four characters of sixteen ticks per bit
  localparam logic [7:0] UFIC_IEN_RST  = 8'h00;
  localparam logic [7:0] UFIC_LCTL_RST = 8'h00;

  // ****************************************
  // carriers and state
  // ****************************************
  typedef struct packed {
    logic [2:0] err;  // [0] parity, [1] framing, [2] break
    logic [7:0] ch;
  } ufic_rx_ent_s;

  typedef struct packed {
    ufic_rx_ent_s [15:0] rx_mem;
    logic [3:0]          rx_rd, rx_wr;
    logic [4:0]          rx_cnt;
    logic [15:0][7:0]    tx_mem;
    logic [3:0]          tx_rd, tx_wr;
    logic [4:0]          tx_cnt;
    logic                fen, dma_mode;
    logic [1:0]          trig;
    logic [3:0]          ien;
    logic [7:0]          lctl;
    logic [3:0]          ls_err;  // [0] overrun [1] parity [2] framing [3] break
    logic                top_rep;
    logic [3:0]          msr_delta;
    logic [9:0]          to_cnt;
    logic                to_pend;
    logic                transmit_holding_empty_pend, transmit_holding_empty_wait, tx_two;
    logic [7:0]          transmit_holding_empty_dly;
    logic                bus_wait;
    logic [7:0]          rdata;
    logic                irq, rxdma_n, txdma_n, txval;
    logic [7:0]          txdata;
  } ufic_state_s;

  // reset image of the whole state
  function automatic ufic_state_s ufic_rst_state();
    ufic_state_s s;
    s          = '0;
    s.ien      = UFIC_IEN_RST[3:0];
    s.lctl     = UFIC_LCTL_RST;
    s.bus_wait = 1'b1;
    s.rxdma_n  = 1'b1;
    return s;
  endfunction : ufic_rst_state

endpackage : ufic_pkg

// ### hw/ufic_top.sv
// fifo control, interrupt priority and identification of a serial element
// assumes an avalon-mm master, a receiver that pushes whole characters and
// a transmit shifter that takes characters; all inputs synchronous to sys_clk
`timescale 1ns/10ps
`default_nettype none

module ufic_top
  import ufic_pkg::*;
(
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  // avalon-mm slave
  input  wire logic [4:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  output var  logic [31:0]  avs_readdata,
  output var  logic         avs_waitrequest,
  // receiver side
  input  wire logic         rcv_clk_en,
  input  wire logic         rx_push,
  input  wire ufic_rx_ent_s rx_char,
  // transmitter side
  input  wire logic         tx_take,
  input  wire logic         tx_shift_busy,
  output var  logic [7:0]   tx_char,
  output var  logic         tx_valid,
  // modem lines
  input  wire logic [3:0]   modem_change,
  input  wire logic [3:0]   modem_level,
  // interrupt and dma handshakes
  output var  logic         interrupt_out,
  output var  logic         receive_dma_request_n,
  output var  logic         transmit_dma_request_n
);

  // ****************************************
  // helpers
  // ****************************************

  // bits on the line per character, optionally with the second stop bit
  function automatic logic [3:0] ufic_char_bits(input logic [7:0] lc, input logic extra);
    ufic_char_bits = 4'h7 + {2'b00, lc[1:0]} + {3'b000, lc[UFIC_LC_PEN]}
                     + {3'b000, lc[UFIC_LC_STB] & extra};
  endfunction : ufic_char_bits

  // receive trigger level from the two select bits
  function automatic logic [4:0] ufic_trig_lvl(input logic [1:0] sel);
    case (sel)
      2'b00:   ufic_trig_lvl = UFIC_TRIG_L0;
      2'b01:   ufic_trig_lvl = UFIC_TRIG_L1;
      2'b10:   ufic_trig_lvl = UFIC_TRIG_L2;
      default: ufic_trig_lvl = UFIC_TRIG_L3;
    endcase
  endfunction : ufic_trig_lvl

  // identification code of the highest pending source
  function automatic logic [3:0] ufic_iid(input ufic_state_s s);
    logic rls, rda, cto, transmit_holding, msi;
    rls = s.ien[2] & (|s.ls_err);
    rda = s.ien[0] & (s.fen ? (s.rx_cnt >= ufic_trig_lvl(s.trig)) : (s.rx_cnt != 5'h00));
    cto = s.ien[0] & s.fen & s.to_pend;
    transmit_holding = s.ien[1] & s.transmit_holding_empty_pend;
    msi = s.ien[3] & (|s.msr_delta);
    if (rls) begin
      ufic_iid = UFIC_IID_RLS;
    end else if (rda) begin
      ufic_iid = UFIC_IID_RDA;
    end else if (cto) begin
      // time-out code only in fifo mode
      ufic_iid = UFIC_IID_CTO;
    end else if (transmit_holding) begin
      ufic_iid = UFIC_IID_TRANSMIT_HOLDING_EMPTY;
    end else if (msi) begin
      ufic_iid = UFIC_IID_MSI;
    end else begin
      ufic_iid = UFIC_IID_NONE;
    end
  endfunction : ufic_iid

  // ****************************************
  // state
  // ****************************************
  ufic_state_s q, d;

  logic [2:0] idx;
  assign idx = avs_address[4:2];

  // next state of the whole block
  always_comb begin
    logic       rx_pop, tx_push, iid_rd, lsr_rd, msr_rd, fc_wr, divisor_access_bit, to_act, tx_pop;
    logic [7:0] wd, rd, fc;
    logic [4:0] cap, trig;
    logic [3:0] iid_q;
    logic       err_any;
    d       = q;
    rx_pop  = 1'b0;
    tx_push = 1'b0;
    iid_rd  = 1'b0;
    lsr_rd  = 1'b0;
    msr_rd  = 1'b0;
    fc_wr   = 1'b0;
    wd      = avs_writedata[7:0];
    rd      = 8'h00;
    fc      = 8'h00;
    divisor_access_bit    = q.lctl[UFIC_LC_DIVISOR_ACCESS_BIT];
    cap     = q.fen ? UFIC_DEPTH : UFIC_CHR_CAP;
    iid_q   = ufic_iid(q);
    err_any = 1'b0;
    to_act  = 1'b0;
    tx_pop  = 1'b0;
    trig    = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (5'(i) < q.rx_cnt) begin
        err_any = err_any | (|q.rx_mem[4'(q.rx_rd + 4'(i))].err);
      end
    end

    // bus slave: take a request while waitrequest is high, answer next cycle
    d.bus_wait = 1'b1;
    if ((avs_read || avs_write) && q.bus_wait) begin
      d.bus_wait = 1'b0;
      if (avs_read) begin
        case (idx)
          UFIC_IDX_DATA: begin
            // data window hidden while divisor access is set
            if (!divisor_access_bit) begin
              rd     = q.rx_mem[q.rx_rd].ch;
              rx_pop = (q.rx_cnt != 5'h00);
            end
          end
          UFIC_IDX_IEN: begin
            rd = divisor_access_bit ? 8'h00 : {4'h0, q.ien};
          end
          UFIC_IDX_IID: begin
            // read side of the shared address
            // fifo mode flags and zero bits
            // bit 0 low when something is pending
            rd     = {q.fen, q.fen, 2'b00, iid_q};
            iid_rd = 1'b1;
          end
          UFIC_IDX_LCTL: begin
            rd = q.lctl;
          end
          UFIC_IDX_LSTAT: begin
            rd = {err_any & q.fen, (q.tx_cnt == 5'h00) & !tx_shift_busy,
                  q.tx_cnt == 5'h00, q.ls_err, q.rx_cnt != 5'h00};
            lsr_rd = 1'b1;
          end
          UFIC_IDX_MSTAT: begin
            rd     = {modem_level, q.msr_delta};
            msr_rd = 1'b1;
          end
          default: rd = 8'h00;
        endcase
      end else begin
        case (idx)
          UFIC_IDX_DATA: tx_push = !divisor_access_bit;
          UFIC_IDX_IEN: begin
            if (!divisor_access_bit) begin
              d.ien = wd[3:0];
              // enabling the transmit source with an empty fifo raises it
              if (wd[1] && !q.ien[1] && q.tx_cnt == 5'h00) begin
                d.transmit_holding_empty_pend = 1'b1;
              end
            end
          end
          UFIC_IDX_IID: begin
            // write side of the shared address
            fc_wr = 1'b1;
            fc    = wd;
          end
          UFIC_IDX_LCTL: d.lctl = wd;
          default: ;
        endcase
      end
      d.rdata = rd;
    end

    // line status read clears errors, new ones win
    if (lsr_rd) begin
      d.ls_err = 4'h0;
    end
    if (msr_rd) begin
      d.msr_delta = 4'h0;
    end
    d.msr_delta = d.msr_delta | modem_change;

    // receive buffer read pops one character
    if (rx_pop) begin
      d.rx_rd   = q.rx_rd + 4'h1;
      d.rx_cnt  = q.rx_cnt - 5'h01;
      d.top_rep = 1'b0;
    end
    // receiver push with error bits, overrun when full
    if (rx_push) begin
      if (d.rx_cnt < cap) begin
        d.rx_mem[q.rx_wr] = rx_char;
        d.rx_wr           = q.rx_wr + 4'h1;
        d.rx_cnt          = d.rx_cnt + 5'h01;
      end else begin
        d.ls_err[0] = 1'b1;
      end
    end

    // transmit fifo: shifter takes the head, host pushes the tail
    tx_pop = tx_take && (q.tx_cnt != 5'h00);
    if (tx_pop) begin
      d.tx_rd  = q.tx_rd + 4'h1;
      d.tx_cnt = q.tx_cnt - 5'h01;
    end
    if (tx_push) begin
      d.transmit_holding_empty_pend = 1'b0;
      d.transmit_holding_empty_wait = 1'b0;
      if (d.tx_cnt < cap) begin
        d.tx_mem[q.tx_wr] = wd;
        d.tx_wr           = q.tx_wr + 4'h1;
        d.tx_cnt          = d.tx_cnt + 5'h01;
      end
    end
    // identification read clears transmit-empty when it is shown
    if (iid_rd && iid_q == UFIC_IID_TRANSMIT_HOLDING_EMPTY) begin
      d.transmit_holding_empty_pend = 1'b0;
    end

    // fifo control write; flushes win over same-cycle push and pop
    if (fc_wr) begin
      if (fc[UFIC_FC_EN] != q.fen) begin
        d.fen    = fc[UFIC_FC_EN];
        d.rx_rd  = 4'h0;
        d.rx_wr  = 4'h0;
        d.rx_cnt = 5'h00;
        d.tx_rd  = 4'h0;
        d.tx_wr  = 4'h0;
        d.tx_cnt = 5'h00;
        // first transmit-empty after the change is immediate
        d.transmit_holding_empty_pend = 1'b1;
        d.transmit_holding_empty_wait = 1'b0;
        d.tx_two    = 1'b0;
      end
      // remaining bits only with enable written set
      if (fc[UFIC_FC_EN]) begin
        d.dma_mode = fc[UFIC_FC_DMA];
        d.trig = fc[7:6];
        if (fc[UFIC_FC_RXCLR]) begin
          d.rx_rd  = 4'h0;
          d.rx_wr  = 4'h0;
          d.rx_cnt = 5'h00;
        end
        if (fc[UFIC_FC_TXCLR]) begin
          d.tx_rd  = 4'h0;
          d.tx_wr  = 4'h0;
          d.tx_cnt = 5'h00;
        end
      end
    end

    // errors of the character now at the head are shown once
    if (d.rx_cnt == 5'h00) begin
      d.top_rep = 1'b0;
    end else if (!d.top_rep) begin
      d.ls_err[3:1] = d.ls_err[3:1] | d.rx_mem[d.rx_rd].err;
      d.top_rep     = 1'b1;
    end

    // timer runs only with fifo and receive interrupt enabled
    to_act = d.fen && d.ien[0] && (d.rx_cnt != 5'h00);
    // read clears a pending time-out and the timer
    if (rx_pop || !to_act) begin
      d.to_pend = 1'b0;
      d.to_cnt  = 10'h000;
    end else if (rx_push && !q.to_pend) begin
      d.to_cnt = 10'h000;
    end else if (rcv_clk_en && !q.to_pend) begin
      // four character times incl. second stop bit
      if (q.to_cnt >= 10'(ufic_char_bits(q.lctl, 1'b1)) * UFIC_TO_TICKS - 10'h001) begin
        d.to_pend = 1'b1;
      end else begin
        d.to_cnt = q.to_cnt + 10'h001;
      end
    end

    // two bytes held together since the fifo last emptied
    if (d.tx_cnt >= 5'h02) begin
      d.tx_two = 1'b1;
    end
    // transmit fifo emptied by the shifter
    if (tx_pop && d.tx_cnt == 5'h00 && !tx_push) begin
      if (q.tx_two || !q.fen) begin
        d.transmit_holding_empty_pend = 1'b1;
      end else begin
        d.transmit_holding_empty_wait = 1'b1;
        d.transmit_holding_empty_dly  = 8'h00;
      end
      d.tx_two = 1'b0;
    end else if (q.transmit_holding_empty_wait && d.transmit_holding_empty_wait && rcv_clk_en) begin
      // one character time less its stop bits
      if (q.transmit_holding_empty_dly >= 8'(ufic_char_bits(q.lctl, 1'b0) - 4'h1) * UFIC_TICKS - 8'h01) begin
        d.transmit_holding_empty_pend = 1'b1;
        d.transmit_holding_empty_wait = 1'b0;
      end else begin
        d.transmit_holding_empty_dly = q.transmit_holding_empty_dly + 8'h01;
      end
    end

    // interrupt output follows the enabled pending sources
    // enables gate the sources inside the priority encoder
    d.irq = (ufic_iid(d) != UFIC_IID_NONE);

    // receive dma: mode 0 any data, mode 1 trigger or time-out until empty
    trig = ufic_trig_lvl(d.trig);
    if (d.fen && d.dma_mode) begin
      if (q.rxdma_n) begin
        d.rxdma_n = !((d.rx_cnt >= trig) || d.to_pend);
      end else begin
        d.rxdma_n = (d.rx_cnt == 5'h00);
      end
      d.txdma_n = (d.tx_cnt >= UFIC_DEPTH);
    end else begin
      d.rxdma_n = (d.rx_cnt == 5'h00);
      d.txdma_n = (d.tx_cnt != 5'h00);
    end

    // head of the transmit fifo toward the shifter
    d.txdata = d.tx_mem[d.tx_rd];
    d.txval  = (d.tx_cnt != 5'h00);
  end

  // state register with synchronous reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q <= ufic_rst_state();
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************

  // every output straight from the state register
  assign avs_readdata           = {24'h000000, q.rdata};
  assign avs_waitrequest        = q.bus_wait;
  assign tx_char                = q.txdata;
  assign tx_valid               = q.txval;
  assign interrupt_out          = q.irq;
  assign receive_dma_request_n  = q.rxdma_n;
  assign transmit_dma_request_n = q.txdma_n;

endmodule : ufic_top

`default_nettype wire

// ### tb/ufic_top_sva.sv
// assertions on the ports of the fifo control and identification block
// assumes one clock, synchronous reset and a master that holds its requests
`timescale 1ns/10ps
`default_nettype none
module ufic_top_sva
  import ufic_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // register bus
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // link side and outputs
  input wire logic        rx_push,
  input wire logic        tx_valid,
  input wire logic        interrupt_out,
  input wire logic        receive_dma_request_n,
  input wire logic        transmit_dma_request_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic       tk, wr_c, rd_id, fen_q, dl_q;
  logic [2:0] ix;
  // taken access, control write, identification answer
  assign ix    = avs_address[4:2];
  assign tk    = (avs_read | avs_write) & avs_waitrequest;
  assign wr_c  = tk & avs_write & (ix == UFIC_IDX_IID);
  assign rd_id = avs_read & ~avs_waitrequest & (ix == UFIC_IDX_IID);
  // shadow of the enable bit and the divisor access bit
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fen_q <= 1'b0;
      dl_q  <= 1'b0;
    end else begin
      if (wr_c) fen_q <= avs_writedata[0];
      if (tk && avs_write && ix == UFIC_IDX_LCTL) dl_q <= avs_writedata[7];
    end
  end
  property p_ack; (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("request not answered");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("answer longer than one cycle");
  property p_ien; avs_read && !avs_waitrequest && ix == UFIC_IDX_IEN |-> avs_readdata[31:4] == 0;
  endproperty
  a_ien: assert property (p_ien) else $error("enable upper bits not zero");
  property p_code; rd_id |-> avs_readdata[3:0] inside {4'h1, 4'h6, 4'h4, 4'hC, 4'h2, 4'h0};
  endproperty
  a_code: assert property (p_code) else $error("illegal identification code");
  property p_top; rd_id |-> avs_readdata[7:4] == {fen_q, fen_q, 2'b00}; endproperty
  a_top: assert property (p_top) else $error("identification top bits wrong");
  property p_b3; rd_id && avs_readdata[3] |-> avs_readdata[2] && fen_q; endproperty
  a_b3: assert property (p_b3) else $error("time-out flag outside fifo mode");
  property p_flen; wr_c && avs_writedata[0] != fen_q |-> ##[1:2] !tx_valid; endproperty
  a_flen: assert property (p_flen) else $error("enable change kept data");
  property p_fltx; wr_c && avs_writedata[0] && avs_writedata[2] |-> ##[1:2] !tx_valid;
  endproperty
  a_fltx: assert property (p_fltx) else $error("transmit flush kept data");
  property p_flrx; wr_c && avs_writedata[1:0] == 2'b11 ##1 !rx_push |=> receive_dma_request_n;
  endproperty
  a_flrx: assert property (p_flrx) else $error("receive flush kept data");
  property p_txdma; !tx_valid && !$past(tx_valid) |-> !transmit_dma_request_n; endproperty
  a_txdma: assert property (p_txdma) else $error("transmit request idle while empty");
  property p_irq; tk && avs_write && ix == UFIC_IDX_IEN && !dl_q && avs_writedata[3:0] == 4'h0
    |-> ##2 !interrupt_out; endproperty
  a_irq: assert property (p_irq) else $error("interrupt with all sources off");
endmodule : ufic_top_sva
bind ufic_top ufic_top_sva ufic_top_sva_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .rx_push(rx_push), .tx_valid(tx_valid),
  .interrupt_out(interrupt_out), .receive_dma_request_n(receive_dma_request_n),
  .transmit_dma_request_n(transmit_dma_request_n));
`default_nettype wire

// ### tb/ufic_serial_model.sv
// serial side model: receiver ticks, received characters, transmit shifter
// assumes the bench calls send and drives take_en after clock edges
`timescale 1ns/10ps
`default_nettype none
module ufic_serial_model
  import ufic_pkg::*;
(
  // clock and control
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic         take_en,
  // receiver side
  output var  logic         rcv_clk_en,
  output var  logic         rx_push,
  output var  ufic_rx_ent_s rx_char,
  // transmitter side
  input  wire logic         tx_valid,
  output var  logic         tx_take
);
  initial begin
    rx_push = 1'b0;
    rx_char = '0;
  end
  // receiver tick every second cycle, so character times scale with it
  always @(posedge sys_clk) rcv_clk_en <= sys_rst ? 1'b0 : ~rcv_clk_en;
  // shifter takes the head every second cycle while allowed
  always @(posedge sys_clk) tx_take <= !sys_rst && take_en && tx_valid && !tx_take;
  // one character per call; the data lines are scrambled once released
  task automatic send(input logic [7:0] c);
    @(posedge sys_clk);
    rx_push <= 1'b1;
    rx_char <= {3'h0, c};
    @(posedge sys_clk);
    rx_push <= 1'b0;
    rx_char <= ~{3'h0, c};
  endtask : send
endmodule : ufic_serial_model
`default_nettype wire

// ### tb/tb.sv
// bench of the fifo control and identification block
// assumes the serial model supplies receiver ticks, characters and takes
`timescale 1ns/10ps
`default_nettype none
module tb
  import ufic_pkg::*;
;
  logic         sys_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0]   avs_address = 5'h00;
  logic [31:0]  avs_writedata = 32'h0, avs_readdata;
  logic         avs_waitrequest, rcv_clk_en, rx_push, tx_take, tx_valid, interrupt_out;
  logic         take_en = 1'b0, rx_dma_n, tx_dma_n, shift_busy = 1'b0;
  logic [3:0]   m_chg = 4'h0, m_lvl = 4'h0;
  logic [7:0]   tx_char, q;
  ufic_rx_ent_s rx_char;
  logic [4:0]   lvl [4] = '{UFIC_TRIG_L0, UFIC_TRIG_L1, UFIC_TRIG_L2, UFIC_TRIG_L3};
  int           n_mismatch = 0, checks = 0;
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error %0t: got %h expected %h", $time, a, e); end end
  ufic_top ufic_top_inst (.sys_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .rcv_clk_en, .rx_push, .rx_char,
    .tx_take, .tx_shift_busy(shift_busy), .tx_char, .tx_valid, .modem_change(m_chg),
    .modem_level(m_lvl), .interrupt_out, .receive_dma_request_n(rx_dma_n),
    .transmit_dma_request_n(tx_dma_n));
  ufic_serial_model ufic_serial_model_inst (.sys_clk, .sys_rst, .take_en, .rcv_clk_en,
    .rx_push, .rx_char, .tx_valid, .tx_take);
  always #5 sys_clk = ~sys_clk;
  task automatic end_sim();
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  task automatic fail();
    n_mismatch++;
    $display("Error %0t: wait timed out", $time);
    end_sim();
  endtask : fail
  // one bus access, held until waitrequest is sampled low; divisor bit left clear
  task automatic bus(input logic w, input logic [2:0] i, input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    avs_address   <= {i, 2'b00};
    avs_read      <= !w;
    avs_write     <= w;
    avs_writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) fail();
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask : wr
  task automatic rd_chk(input logic [2:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    `CHK(q, e)
  endtask : rd_chk
  // let the shifter empty the transmit fifo
  task automatic drain();
    int n;
    take_en <= 1'b1;
    for (n = 0; n < 50 && tx_valid !== 1'b0; n++) @(posedge sys_clk);
    if (n == 50) fail();
  endtask : drain
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd_chk(UFIC_IDX_IID, {4'h0, UFIC_IID_NONE});
    wr(UFIC_IDX_IEN, 8'hFF);
    rd_chk(UFIC_IDX_IEN, 8'h0F);
    wr(UFIC_IDX_IID, 8'hC8);
    rd_chk(UFIC_IDX_IID, {4'h0, UFIC_IID_TRANSMIT_HOLDING_EMPTY});
    rd_chk(UFIC_IDX_IID, {4'h0, UFIC_IID_NONE});
    // dma signalling modes with one character below trigger four
    wr(UFIC_IDX_IEN, 8'h00);
    wr(UFIC_IDX_IID, 8'h41);
    ufic_serial_model_inst.send(8'h5A);
    repeat (2) @(posedge sys_clk);
    `CHK(rx_dma_n, 1'b0)
    wr(UFIC_IDX_IID, 8'h4B);
    ufic_serial_model_inst.send(8'h5A);
    repeat (2) @(posedge sys_clk);
    `CHK(rx_dma_n, 1'b1)
    rd_chk(UFIC_IDX_LSTAT, 8'h61);
    wr(UFIC_IDX_IID, 8'h4B);
    rd_chk(UFIC_IDX_LSTAT, 8'h60);
    // every trigger level, just below and at the level
    wr(UFIC_IDX_IEN, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(UFIC_IDX_IID, {k[1:0], 6'h03});
      repeat (int'(lvl[k]) - 1) ufic_serial_model_inst.send(8'h3C);
      rd_chk(UFIC_IDX_IID, {4'hC, UFIC_IID_NONE});
      ufic_serial_model_inst.send(8'hA5);
      rd_chk(UFIC_IDX_IID, {4'hC, UFIC_IID_RDA});
      `CHK(interrupt_out, 1'b1)
    end
    rd_chk(UFIC_IDX_DATA, 8'h3C);
    rd_chk(UFIC_IDX_IID, {4'hC, UFIC_IID_NONE});
    // time-out runs on receiver ticks, not on the system clock
    repeat (600) @(posedge sys_clk);
    rd_chk(UFIC_IDX_IID, {4'hC, UFIC_IID_NONE});
    repeat (400) @(posedge sys_clk);
    rd_chk(UFIC_IDX_IID, {4'hC, UFIC_IID_CTO});
    rd_chk(UFIC_IDX_DATA, 8'h3C);
    rd_chk(UFIC_IDX_IID, {4'hC, UFIC_IID_NONE});
    // polled operation with data above trigger one
    wr(UFIC_IDX_IEN, 8'h00);
    wr(UFIC_IDX_IID, 8'h01);
    rd_chk(UFIC_IDX_IID, {4'hC, UFIC_IID_NONE});
    `CHK(interrupt_out, 1'b0)
    // transmit-empty set, cleared by read, immediate and delayed
    wr(UFIC_IDX_IEN, 8'h02);
    rd_chk(UFIC_IDX_IID, {4'hC, UFIC_IID_TRANSMIT_HOLDING_EMPTY});
    rd_chk(UFIC_IDX_IID, {4'hC, UFIC_IID_NONE});
    wr(UFIC_IDX_DATA, 8'h11);
    wr(UFIC_IDX_DATA, 8'h22);
    `CHK(tx_char, 8'h11)
    `CHK(tx_dma_n, 1'b1)
    drain();
    repeat (4) @(posedge sys_clk);
    rd_chk(UFIC_IDX_IID, {4'hC, UFIC_IID_TRANSMIT_HOLDING_EMPTY});
    wr(UFIC_IDX_DATA, 8'h33);
    repeat (20) @(posedge sys_clk);
    rd_chk(UFIC_IDX_IID, {4'hC, UFIC_IID_NONE});
    repeat (250) @(posedge sys_clk);
    rd_chk(UFIC_IDX_IID, {4'hC, UFIC_IID_TRANSMIT_HOLDING_EMPTY});
    // received data outranks transmit-empty
    wr(UFIC_IDX_IEN, 8'h00);
    wr(UFIC_IDX_IEN, 8'h03);
    rd_chk(UFIC_IDX_IID, {4'hC, UFIC_IID_RDA});
    wr(UFIC_IDX_IID, 8'h03);
    rd_chk(UFIC_IDX_IID, {4'hC, UFIC_IID_TRANSMIT_HOLDING_EMPTY});
    // transmit flush, then leaving fifo mode empties both
    take_en <= 1'b0;
    shift_busy <= 1'b1;
    ufic_serial_model_inst.send(8'h77);
    wr(UFIC_IDX_DATA, 8'h44);
    wr(UFIC_IDX_IID, 8'h05);
    `CHK(tx_valid, 1'b0)
    rd_chk(UFIC_IDX_LSTAT, 8'h21);
    shift_busy <= 1'b0;
    wr(UFIC_IDX_DATA, 8'h44);
    wr(UFIC_IDX_IID, 8'h00);
    `CHK(tx_valid, 1'b0)
    rd_chk(UFIC_IDX_LSTAT, 8'h60);
    rd_chk(UFIC_IDX_IID, {4'h0, UFIC_IID_TRANSMIT_HOLDING_EMPTY});
    rd_chk(3'h4, 8'h00);
    // modem status source, lowest priority, cleared by its read
    m_lvl <= 4'hA;
    wr(UFIC_IDX_IEN, 8'h08);
    m_chg <= 4'h5;
    @(posedge sys_clk);
    m_chg <= 4'h0;
    rd_chk(UFIC_IDX_IID, {4'h0, UFIC_IID_MSI});
    rd_chk(UFIC_IDX_MSTAT, 8'hA5);
    rd_chk(UFIC_IDX_IID, {4'h0, UFIC_IID_NONE});
    end_sim();
  end
endmodule : tb
`default_nettype wire
